// File: core/thermo_consts.svh
// register offsets, field positions and reset values of the setpoint and hysteresis block
`ifndef THERMO_CONSTS_SVH
`define THERMO_CONSTS_SVH
`define OFF_CTRL 8'h00
`define OFF_BASIC_SP 8'h04
`define OFF_ACTUAL 8'h08
`define OFF_LIM_BUS 8'h0c
`define OFF_LIM_ROT 8'h10
`define OFF_OFFSET 8'h14
`define OFF_DEAD_ZONE 8'h18
`define OFF_HYST 8'h1c
`define OFF_REDUCE 8'h20
`define OFF_INCREASE 8'h24
`define OFF_PROTECT 8'h28
`define OFF_ADD_STAGE 8'h2c
`define OFF_STATUS 8'h30
`define OFF_CUR_SP 8'h34
`define OFF_ROTARY 8'h38
`define CTRL_HEAT_2P 0
`define CTRL_COOL_2P 1
`define CTRL_HC_AUTO 2
`define CTRL_HC_COOL 3
`define CTRL_HEAT_POS 4
`define CTRL_ROT_SRC 5
`define CTRL_MODE_LO 6
`define CTRL_MODE_HI 8
`define CTRL_W 9
`define CTRL_RST 9'h005
`define BASIC_SP_RST 16'h0c1a
`define ACTUAL_RST 16'h07d0
`define LIM_BUS_RST 32'h0bb8_03e8
`define LIM_ROT_RST 32'h0a8c_05dc
`define OFFSET_RST 16'h0000
`define DEAD_ZONE_RST 16'h0190
`define HYST_RST 32'h0064_0064
`define REDUCE_RST 32'h0190_00c8
`define INCREASE_RST 32'h0190_00c8
`define PROTECT_RST 32'h0dac_02bc
`define ADD_STAGE_RST 32'h0032_0064
`define ROTARY_RST 16'h0834
`define VAR_SHIFT 1
`define VAR_FULL 8'hff
`endif

// File: core/thermo_pkg.sv
// types shared by the setpoint and hysteresis block
package thermo_pkg;
  typedef enum logic [2:0] {
    MODE_COMFORT = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_NIGHT = 3'h3,
    MODE_FROST = 3'h2,
    MODE_HEAT_PROT = 3'h6
  } op_mode_t;
  typedef logic signed [17:0] temp_t;
endpackage

// File: core/thermostat_setpoint_hysteresis.sv
// setpoint chain, dead zone and two-point hysteresis decisions with avalon-mm registers
// Operation
// [RL1] negative heat hysteresis: off at setpoint, on below
// [RL2] negative cooling: off at setpoint minus hysteresis
// [RL3] positive heat hysteresis: off at setpoint plus hysteresis
// [RL4] no heating or cooling inside dead zone
// [RL5] both continuous: dead zone width unchanged
// [RL6] one two-point stage widens dead zone
// [RL7] both two-point: widen by both hystereses
// [RL8] basic setpoint is comfort target, reduction reference
// [RL9] bus writes basic setpoint in EIS5 anytime
// [RL10] reset keeps last used basic setpoint
// [RL11] basic setpoint clamped to bus/rotary bounds
// [RL12] manual offset added to bounded basic setpoint
// [RL13] heat/cool chosen automatically or by bus
// [RL14] cooling raises setpoint by dead zone
// [RL15] frost mode replaces setpoint with frost value
// [RL16] heat protection replaces setpoint with its value
// [RL17] reductions, increases, then clamp frost..heat protection
// [RL18] control against current setpoint, not basic
// [RL19] two-point on/off; continuous gives control variable
// [RL20] additional stage parallel, setpoint lowered by differential
// [RL21] re-evaluate on each write, else hold outputs
`timescale 1ns/1ps
`include "thermo_consts.svh"
module thermostat_setpoint_hysteresis
  import thermo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic heat_on,
  output logic cool_on,
  output logic add_on,
  output logic [7:0] heat_var,
  output logic [7:0] cool_var
);

  function automatic temp_t sx(input logic [15:0] v);
    sx = temp_t'(signed'(v));
  endfunction

  function automatic temp_t clampv(input temp_t v, input temp_t lo, input temp_t hi);
    if (v < lo) begin
      clampv = lo;
    end else if (v > hi) begin
      clampv = hi;
    end else begin
      clampv = v;
    end
  endfunction

  // EIS5: sign, 4-bit exponent, 11-bit mantissa, value 0.01 * m * 2^e
  function automatic logic signed [27:0] eis5_fixed(input logic [15:0] d);
    logic signed [11:0] m;
    m = {d[15], d[10:0]};
    eis5_fixed = 28'(signed'(m)) <<< d[14:11];
  endfunction

  function automatic logic signed [27:0] clamp28(input logic signed [27:0] v, input logic [15:0] lo,
                                                 input logic [15:0] hi);
    logic signed [27:0] l;
    logic signed [27:0] h;
    l = 28'(signed'(lo));
    h = 28'(signed'(hi));
    if (v < l) begin
      clamp28 = l;
    end else if (v > h) begin
      clamp28 = h;
    end else begin
      clamp28 = v;
    end
  endfunction

  // saturating proportional variable, 0 .. full scale
  function automatic logic [7:0] sat_var(input temp_t dev);
    temp_t s;
    s = dev >>> `VAR_SHIFT;
    if (dev <= 0) begin
      sat_var = 8'h00;
    end else if (s > temp_t'(`VAR_FULL)) begin
      sat_var = `VAR_FULL;
    end else begin
      sat_var = s[7:0];
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ---------------- bus slave ----------------
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_do;
  logic upd_reg, upd_next;

  logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
  // not under rst: survives a reset so the last used value is kept
  logic [15:0] basic_sp_reg = `BASIC_SP_RST;
  logic [15:0] basic_sp_next;
  logic [15:0] actual_reg, actual_next;
  logic [31:0] lim_bus_reg, lim_bus_next;
  logic [31:0] lim_rot_reg, lim_rot_next;
  logic [15:0] offset_reg, offset_next;
  logic [15:0] dead_zone_reg, dead_zone_next;
  logic [31:0] hyst_reg, hyst_next;
  logic [31:0] reduce_reg, reduce_next;
  logic [31:0] increase_reg, increase_next;
  logic [31:0] protect_reg, protect_next;
  logic [31:0] add_stage_reg, add_stage_next;
  logic [15:0] rotary_reg, rotary_next;

  logic heat_reg, heat_next;
  logic cool_reg, cool_next;
  logic add_reg, add_next;
  logic cooling_reg, cooling_next;
  temp_t cur_sp_reg, cur_sp_next;
  logic [7:0] heat_var_reg, heat_var_next;
  logic [7:0] cool_var_reg, cool_var_next;

  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_do = write & ack_reg;
  assign readdata = rdata_reg;

  logic [31:0] rd_mux;
  // old word of the addressed register merged with the enabled write lanes
  logic [31:0] wm;
  always_comb begin
    if (address == `OFF_CTRL) begin
      rd_mux = 32'(ctrl_reg);
    end else if (address == `OFF_BASIC_SP) begin
      rd_mux = {16'h0000, basic_sp_reg};
    end else if (address == `OFF_ACTUAL) begin
      rd_mux = {16'h0000, actual_reg};
    end else if (address == `OFF_LIM_BUS) begin
      rd_mux = lim_bus_reg;
    end else if (address == `OFF_LIM_ROT) begin
      rd_mux = lim_rot_reg;
    end else if (address == `OFF_OFFSET) begin
      rd_mux = {16'h0000, offset_reg};
    end else if (address == `OFF_DEAD_ZONE) begin
      rd_mux = {16'h0000, dead_zone_reg};
    end else if (address == `OFF_HYST) begin
      rd_mux = hyst_reg;
    end else if (address == `OFF_REDUCE) begin
      rd_mux = reduce_reg;
    end else if (address == `OFF_INCREASE) begin
      rd_mux = increase_reg;
    end else if (address == `OFF_PROTECT) begin
      rd_mux = protect_reg;
    end else if (address == `OFF_ADD_STAGE) begin
      rd_mux = add_stage_reg;
    end else if (address == `OFF_STATUS) begin
      rd_mux = {28'h0000000, cooling_reg, add_reg, cool_reg, heat_reg};
    end else if (address == `OFF_CUR_SP) begin
      rd_mux = 32'(cur_sp_reg[15:0]);
    end else if (address == `OFF_ROTARY) begin
      rd_mux = {16'h0000, rotary_reg};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb begin
    wm = merge(rd_mux, writedata, byteenable);
    ack_next = (read | write) & ~ack_reg;
    rdata_next = (read & ~ack_reg) ? rd_mux : rdata_reg;
    upd_next = wr_do;
    ctrl_next = ctrl_reg;
    basic_sp_next = basic_sp_reg;
    actual_next = actual_reg;
    lim_bus_next = lim_bus_reg;
    lim_rot_next = lim_rot_reg;
    offset_next = offset_reg;
    dead_zone_next = dead_zone_reg;
    hyst_next = hyst_reg;
    reduce_next = reduce_reg;
    increase_next = increase_reg;
    protect_next = protect_reg;
    add_stage_next = add_stage_reg;
    rotary_next = rotary_reg;
    if (wr_do) begin
      if (address == `OFF_CTRL) begin
        ctrl_next = wm[`CTRL_W-1:0];
      end else if (address == `OFF_BASIC_SP) begin
        basic_sp_next = wm[15:0]; // [RL9]
      end else if (address == `OFF_ACTUAL) begin
        actual_next = wm[15:0];
      end else if (address == `OFF_LIM_BUS) begin
        lim_bus_next = merge(lim_bus_reg, writedata, byteenable);
      end else if (address == `OFF_LIM_ROT) begin
        lim_rot_next = merge(lim_rot_reg, writedata, byteenable);
      end else if (address == `OFF_OFFSET) begin
        offset_next = wm[15:0];
      end else if (address == `OFF_DEAD_ZONE) begin
        dead_zone_next = wm[15:0];
      end else if (address == `OFF_HYST) begin
        hyst_next = merge(hyst_reg, writedata, byteenable);
      end else if (address == `OFF_REDUCE) begin
        reduce_next = merge(reduce_reg, writedata, byteenable);
      end else if (address == `OFF_INCREASE) begin
        increase_next = merge(increase_reg, writedata, byteenable);
      end else if (address == `OFF_PROTECT) begin
        protect_next = merge(protect_reg, writedata, byteenable);
      end else if (address == `OFF_ADD_STAGE) begin
        add_stage_next = merge(add_stage_reg, writedata, byteenable);
      end else if (address == `OFF_ROTARY) begin
        rotary_next = wm[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    basic_sp_reg <= basic_sp_next; // [RL10]
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      upd_reg <= 1'b0;
      ctrl_reg <= `CTRL_RST;
      actual_reg <= `ACTUAL_RST;
      lim_bus_reg <= `LIM_BUS_RST;
      lim_rot_reg <= `LIM_ROT_RST;
      offset_reg <= `OFFSET_RST;
      dead_zone_reg <= `DEAD_ZONE_RST;
      hyst_reg <= `HYST_RST;
      reduce_reg <= `REDUCE_RST;
      increase_reg <= `INCREASE_RST;
      protect_reg <= `PROTECT_RST;
      add_stage_reg <= `ADD_STAGE_RST;
      rotary_reg <= `ROTARY_RST;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      upd_reg <= upd_next;
      ctrl_reg <= ctrl_next;
      actual_reg <= actual_next;
      lim_bus_reg <= lim_bus_next;
      lim_rot_reg <= lim_rot_next;
      offset_reg <= offset_next;
      dead_zone_reg <= dead_zone_next;
      hyst_reg <= hyst_next;
      reduce_reg <= reduce_next;
      increase_reg <= increase_next;
      protect_reg <= protect_next;
      add_stage_reg <= add_stage_next;
      rotary_reg <= rotary_next;
    end
  end

  // ---------------- setpoint chain ----------------
  op_mode_t mode;
  logic heat_2p, cool_2p, heat_pos;
  temp_t t_act, hh, ch, dz_eff, base, hsp_base, sp_chain, cur_sp, frost_sp, hprot_sp;
  temp_t add_sp, red, inc;

  always_comb begin
    case (ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO])
      3'(MODE_STANDBY): mode = MODE_STANDBY;
      3'(MODE_NIGHT): mode = MODE_NIGHT;
      3'(MODE_FROST): mode = MODE_FROST;
      3'(MODE_HEAT_PROT): mode = MODE_HEAT_PROT;
      default: mode = MODE_COMFORT;
    endcase
  end

  always_comb begin
    heat_2p = ctrl_reg[`CTRL_HEAT_2P];
    cool_2p = ctrl_reg[`CTRL_COOL_2P];
    heat_pos = ctrl_reg[`CTRL_HEAT_POS];
    t_act = sx(actual_reg);
    hh = sx(hyst_reg[15:0]);
    ch = sx(hyst_reg[31:16]);
    frost_sp = sx(protect_reg[15:0]);
    hprot_sp = sx(protect_reg[31:16]);
    // continuous stages leave the zone as set; each two-point stage adds its hysteresis
    dz_eff = sx(dead_zone_reg) + (heat_2p ? hh : temp_t'(0)) + (cool_2p ? ch : temp_t'(0)); // [RL5] [RL6] [RL7]
    if (ctrl_reg[`CTRL_ROT_SRC]) begin
      base = temp_t'(clamp28(28'(signed'(rotary_reg)), lim_rot_reg[15:0], lim_rot_reg[31:16])); // [RL11]
    end else begin
      base = temp_t'(clamp28(eis5_fixed(basic_sp_reg), lim_bus_reg[15:0], lim_bus_reg[31:16])); // [RL11]
    end
    hsp_base = base + sx(offset_reg); // [RL8] [RL12]
    if (!ctrl_reg[`CTRL_HC_AUTO]) begin
      cooling_next = ctrl_reg[`CTRL_HC_COOL]; // [RL13]
    end else if (t_act > hsp_base + dz_eff) begin
      cooling_next = 1'b1; // [RL13]
    end else if (t_act < hsp_base) begin
      cooling_next = 1'b0;
    end else begin
      cooling_next = cooling_reg;
    end
    case (mode)
      MODE_STANDBY: begin
        red = sx(reduce_reg[15:0]);
        inc = sx(increase_reg[15:0]);
      end
      MODE_NIGHT: begin
        red = sx(reduce_reg[31:16]);
        inc = sx(increase_reg[31:16]);
      end
      default: begin
        red = temp_t'(0);
        inc = temp_t'(0);
      end
    endcase
    if (cooling_next) begin
      sp_chain = hsp_base + dz_eff + inc; // [RL14] [RL17]
    end else begin
      sp_chain = hsp_base - red; // [RL8] [RL17]
    end
    if (mode == MODE_FROST) begin
      sp_chain = frost_sp; // [RL15]
    end else if (mode == MODE_HEAT_PROT) begin
      sp_chain = hprot_sp; // [RL16]
    end
    cur_sp = clampv(sp_chain, frost_sp, hprot_sp); // [RL17]
    add_sp = cur_sp - sx(add_stage_reg[15:0]); // [RL20]
  end

  // ---------------- two-point and continuous decisions ----------------
  always_comb begin
    heat_next = heat_reg;
    cool_next = cool_reg;
    add_next = add_reg;
    cur_sp_next = cur_sp_reg;
    heat_var_next = heat_var_reg;
    cool_var_next = cool_var_reg;
    if (upd_reg) begin // [RL21]
      cur_sp_next = cur_sp; // [RL18]
      if (cooling_next || !heat_2p) begin
        heat_next = 1'b0; // [RL4] [RL19]
      end else if (heat_pos) begin
        if (t_act >= cur_sp + hh) begin
          heat_next = 1'b0; // [RL3]
        end else if (t_act < cur_sp) begin
          heat_next = 1'b1; // [RL3]
        end
      end else begin
        if (t_act >= cur_sp) begin
          heat_next = 1'b0; // [RL1]
        end else if (t_act < cur_sp - hh) begin
          heat_next = 1'b1; // [RL1]
        end
      end
      if (!cooling_next || !cool_2p) begin
        cool_next = 1'b0; // [RL4] [RL19]
      end else if (t_act <= cur_sp - ch) begin
        cool_next = 1'b0; // [RL2]
      end else if (t_act > cur_sp) begin
        cool_next = 1'b1; // [RL2]
      end
      // the additional stage is always two-point with negative hysteresis
      if (cooling_next || t_act >= add_sp) begin
        add_next = 1'b0; // [RL4] [RL20]
      end else if (t_act < add_sp - sx(add_stage_reg[31:16])) begin
        add_next = 1'b1; // [RL20]
      end
      heat_var_next = (cooling_next || heat_2p) ? 8'h00 : sat_var(cur_sp - t_act); // [RL19]
      cool_var_next = (!cooling_next || cool_2p) ? 8'h00 : sat_var(t_act - cur_sp); // [RL19]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      heat_reg <= 1'b0;
      cool_reg <= 1'b0;
      add_reg <= 1'b0;
      cooling_reg <= 1'b0;
      cur_sp_reg <= temp_t'(0);
      heat_var_reg <= 8'h00;
      cool_var_reg <= 8'h00;
    end else begin
      heat_reg <= heat_next;
      cool_reg <= cool_next;
      add_reg <= add_next;
      cooling_reg <= upd_reg ? cooling_next : cooling_reg;
      cur_sp_reg <= cur_sp_next;
      heat_var_reg <= heat_var_next;
      cool_var_reg <= cool_var_next;
    end
  end

  assign heat_on = heat_reg;
  assign cool_on = cool_reg;
  assign add_on = add_reg;
  assign heat_var = heat_var_reg;
  assign cool_var = cool_var_reg;

  // ---------------- assertions ----------------
  a_no_dual_drive: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
    !((heat_on || add_on || heat_var != 8'h00) && (cool_on || cool_var != 8'h00)))
    else $error("heating and cooling driven together");

  a_hold_no_update: assert property (@(posedge clk_sys) disable iff (rst) // [RL21]
    !upd_reg |=> $stable(heat_on) && $stable(cool_on) && $stable(add_on) && $stable(cur_sp_reg))
    else $error("decision changed without an update");

  a_basic_adopt: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
    write && !waitrequest && address == `OFF_BASIC_SP && byteenable == 4'hf
    |=> basic_sp_reg == $past(writedata[15:0]))
    else $error("basic setpoint write not adopted");

  a_frost_replace: assert property (@(posedge clk_sys) disable iff (rst) // [RL15]
    upd_reg && mode == MODE_FROST && frost_sp <= hprot_sp |=> cur_sp_reg == $past(frost_sp))
    else $error("frost mode did not replace setpoint");

  a_hprot_replace: assert property (@(posedge clk_sys) disable iff (rst) // [RL16]
    upd_reg && mode == MODE_HEAT_PROT && frost_sp <= hprot_sp |=> cur_sp_reg == $past(hprot_sp))
    else $error("heat protection did not replace setpoint");

  a_sp_clamped: assert property (@(posedge clk_sys) disable iff (rst) // [RL17]
    upd_reg && frost_sp <= hprot_sp |=> cur_sp_reg >= $past(frost_sp) && cur_sp_reg <= $past(hprot_sp))
    else $error("current setpoint outside protection limits");

  a_neg_heat_off: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
    upd_reg && heat_2p && !heat_pos && t_act >= cur_sp |=> !heat_on)
    else $error("negative hysteresis heating not off at setpoint");

  a_pos_heat_band: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    upd_reg && heat_2p && heat_pos && !cooling_next && t_act < cur_sp |=> heat_on ##1 (heat_on || upd_reg))
    else $error("positive hysteresis heating not on below setpoint");

  a_cool_off_band: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
    upd_reg && cool_2p && cooling_next && t_act <= cur_sp - ch |=> !cool_on)
    else $error("cooling not off at setpoint minus hysteresis");

  a_add_below: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
    upd_reg && !cooling_next && t_act < add_sp - sx(add_stage_reg[31:16]) |=> add_on)
    else $error("additional stage not on below its band");

  a_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("waitrequest held more than one cycle");

endmodule

// File: testbench/bus_partner.sv
// avalon-mm master standing in for the automation bus partner
`timescale 1ns/1ps
module bus_partner (
  input wire logic clk_sys,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end

  // any object, setpoint or heat/cool select, may be written at any time
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do @(posedge clk_sys); while (waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // released lines flip so a stale value never looks valid
    address <= ~a;
    writedata <= ~d;
    byteenable <= ~be;
  endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the setpoint chain and two-point decisions
`timescale 1ns/1ps
`include "thermo_consts.svh"
module tb_top
  import thermo_pkg::*;
;
  logic clk_sys;
  logic rst;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic heat_on;
  logic cool_on;
  logic add_on;
  logic [7:0] heat_var;
  logic [7:0] cool_var;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int b;
  int off;
  logic [31:0] rv [16] = '{`CTRL_RST, `BASIC_SP_RST, `ACTUAL_RST, `LIM_BUS_RST, `LIM_ROT_RST, `OFFSET_RST,
    `DEAD_ZONE_RST, `HYST_RST, `REDUCE_RST, `INCREASE_RST, `PROTECT_RST, `ADD_STAGE_RST, 0, 0, `ROTARY_RST, 0};
  op_mode_t md [5] = '{MODE_COMFORT, MODE_STANDBY, MODE_NIGHT, MODE_FROST, MODE_HEAT_PROT};
  int spm [5] = '{2200, 2000, 1800, 700, 3500};
  int ht [4] = '{1000, 1900, 2099, 2300};

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  thermostat_setpoint_hysteresis dut_u (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .heat_on(heat_on), .cool_on(cool_on), .add_on(add_on),
    .heat_var(heat_var), .cool_var(cool_var));

  bus_partner partner_u (.clk_sys(clk_sys), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // outputs settle one edge after the write completes, so wait three
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    partner_u.xfer(a, 1'b1, be, d, q);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    partner_u.xfer(a, 1'b0, 4'hf, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic outs(input logic [2:0] exp);
    chk("heat cool add", {29'h0, exp}, {29'h0, heat_on, cool_on, add_on});
  endtask

  task automatic seq(input int t [5], input logic [2:0] e [5]);
    foreach (t[i]) begin
      wr(`OFF_ACTUAL, 32'(t[i]));
      outs(e[i]);
    end
  endtask

  task automatic restart();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  function automatic int clampi(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction

  // positive even values only; one exponent step covers the range used
  function automatic logic [31:0] eis5(int v);
    return v < 2048 ? 32'(v) : 32'h0800 | 32'(v >> 1);
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    b = $urandom(32'h20adadc1);
    restart();
    foreach (rv[i]) rd(8'(i * 4), rv[i], "reset value");
    done("reset values");
    wr(`OFF_BASIC_SP, eis5(2200));
    rd(`OFF_BASIC_SP, 32'h0000_0c4c, "basic setpoint");
    seq('{2000, 2150, 2200, 2150, 2099}, '{3'b101, 3'b100, 3'b000, 3'b000, 3'b100});
    rd(`OFF_CUR_SP, 32'd2200, "comfort setpoint");
    repeat (30) @(posedge clk_sys);
    outs(3'b100);
    done("negative hysteresis");
    wr(`OFF_CTRL, 32'h015);
    seq('{2150, 2250, 2300, 2250, 2199}, '{3'b100, 3'b100, 3'b000, 3'b000, 3'b100});
    done("positive hysteresis");
    foreach (md[i]) begin
      wr(`OFF_CTRL, 32'h005 | (32'(md[i]) << `CTRL_MODE_LO));
      rd(`OFF_CUR_SP, 32'(spm[i]), "mode setpoint");
    end
    done("modes");
    wr(`OFF_CTRL, 32'h005);
    wr(`OFF_ACTUAL, 32'd500);
    for (int i = 0; i < 8; i++) begin
      b = i == 0 ? 3000 : 800 + 2 * int'($urandom % 1201);
      off = i == 0 ? 1000 : int'($urandom % 601) - 300;
      wr(`OFF_BASIC_SP, eis5(b));
      wr(`OFF_OFFSET, {16'h0, 16'(off)});
      rd(`OFF_CUR_SP, 32'(clampi(clampi(b, 1000, 3000) + off, 700, 3500)), "chain");
    end
    done("limits and offset");
    wr(`OFF_BASIC_SP, eis5(2200));
    restart();
    rd(`OFF_BASIC_SP, 32'h0000_0c4c, "kept setpoint");
    wr(`OFF_ACTUAL, 32'd2000);
    rd(`OFF_CUR_SP, 32'd2200, "setpoint after reset");
    done("reset keeps setpoint");
    wr(`OFF_BASIC_SP, eis5(2100));
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_CTRL, 32'h008 | 32'(i));
      rd(`OFF_CUR_SP, 32'(2500 + 100 * i[0] + 100 * i[1]), "cooling setpoint");
    end
    rd(`OFF_STATUS, 32'h8, "status");
    done("dead zone");
    wr(`OFF_CTRL, 32'h00a);
    seq('{2700, 2550, 2500, 2550, 2601}, '{3'b010, 3'b010, 3'b000, 3'b000, 3'b010});
    done("cooling hysteresis");
    wr(`OFF_CTRL, 32'h007);
    seq('{1900, 2400, 2800, 2400, 2200}, '{3'b101, 3'b000, 3'b010, 3'b000, 3'b000});
    rd(`OFF_CUR_SP, 32'd2700, "auto cooling setpoint");
    done("automatic selection");
    wr(`OFF_CTRL, 32'h004);
    foreach (ht[i]) begin
      wr(`OFF_ACTUAL, 32'(ht[i]));
      chk("heat var", 32'(clampi((2100 - ht[i]) >>> 1, 0, 255)), {24'h0, heat_var});
      chk("heat on", 32'h0, {31'h0, heat_on});
    end
    done("continuous");
    wr(`OFF_CUR_SP, 32'h1234);
    rd(`OFF_CUR_SP, 32'd2100, "read-only setpoint");
    wr(8'h3c, 32'h5a5a);
    rd(8'h3c, 32'h0, "unmapped");
    wr(`OFF_LIM_ROT, 32'hffff_05de, 4'h3);
    rd(`OFF_LIM_ROT, 32'h0a8c_05de, "byte lanes");
    done("bus");
    wr(`OFF_ROTARY, 32'd3000);
    wr(`OFF_CTRL, 32'h024);
    rd(`OFF_CUR_SP, 32'd2700, "rotary limit");
    wr(`OFF_ACTUAL, 32'd3400);
    chk("cool var", 32'd150, {24'h0, cool_var});
    wr(`OFF_CTRL, 32'h064);
    rd(`OFF_CUR_SP, 32'd3300, "standby cooling setpoint");
    chk("cool var standby", 32'd50, {24'h0, cool_var});
    done("rotary and cooling variable");
    report_and_stop();
  end
endmodule
